// ==== common/lcc_pkg.sv ====
// Shared constants, enumerations and carriers of the logic cell cluster.
// Assumes one 100 MHz clock; every file refers to names here by lcc_pkg::.
package lcc_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int N_CELLS = 8;            // Cells in one cluster
  localparam int N_CTRL = 4;             // Shared control signals
  localparam int N_DCLK = 2;             // Dedicated clock pins
  localparam int N_GLOBAL = 4;           // Global control signals
  localparam int N_IO = 4;               // I/O pins offered as controls
  localparam int N_ROW = 8;              // Row lines into local interconnect
  localparam int LUT_IN = 4;             // Lookup table inputs
  localparam int LUT_W = 16;             // Lookup table mask bits
  localparam int SEL_W = 4;              // Width of every source index
  localparam int SEL_SPAN = 16;          // Sources one index can reach
  localparam int SYNC_STAGES = 2;        // Flops on each pin input

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_CLK0 = 0;          // First cluster clock
  localparam int CTRL_CLK1 = 1;          // Second cluster clock
  localparam int CTRL_CLR = 2;           // Cluster clear, active low
  localparam int CTRL_PRE = 3;           // Cluster preset, active low
  localparam int IN_CARRY = 2;           // Lookup input taken by carry
  localparam int IN_SECOND = 3;          // Data input used as K or R

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic Q_RESET = 1'h0;       // Cell register after reset
  localparam logic OUT_RESET = 1'h0;     // Output registers after reset
  localparam logic SYNC_RESET = 1'h0;    // Synchroniser flops after reset

  // ----------------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LCC_FF_D, LCC_FF_T, LCC_FF_JK, LCC_FF_SR
  } lcc_ff_mode_t;

  typedef enum logic {
    LCC_OUT_LUT, LCC_OUT_REG
  } lcc_out_src_t;

  typedef enum logic [1:0] {
    LCC_SRC_DCLK, LCC_SRC_GLOBAL, LCC_SRC_IO, LCC_SRC_LOCAL
  } lcc_src_kind_t;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    lcc_src_kind_t kind;                 // Source family
    logic [SEL_W-1:0] idx;               // Index within the family
    logic invert;                        // Programmable inversion
  } lcc_ctrl_cfg_t;

  typedef struct packed {
    logic [LUT_W-1:0] lut_mask;          // Truth table, input word indexes
    logic [LUT_IN-1:0][SEL_W-1:0] in_sel; // Local bus index per input
    logic ena_use;                       // Use a clock enable
    logic [SEL_W-1:0] ena_sel;           // Local bus index of the enable
    lcc_ff_mode_t ff_mode;               // Register behaviour
    logic bypass;                        // Pure combinatorial cell
    lcc_out_src_t local_src;             // Local output source
    lcc_out_src_t row_src;               // Row output source
    logic clk_sel;                       // Which cluster clock
    logic use_clr;                       // Follow cluster clear
    logic use_pre;                       // Follow cluster preset
    logic carry_en;                      // Join the carry link
    logic cascade_en;                    // Join the cascade link
  } lcc_cell_cfg_t;

  typedef struct packed {
    logic lut;                           // Lookup result after cascade
    logic q;                             // Register state
    logic local_o;                       // Local output value
    logic row_o;                         // Row output value
  } lcc_cell_out_t;

endpackage : lcc_pkg

// ==== core/lcc_sync.sv ====
// Two-flop synchroniser for a group of pin levels.
// Assumes levels that change slowly against the 100 MHz clock.
module lcc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta; // First stage, read only by the second

  // Both stages take the reset constant, then shift
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= {W{lcc_pkg::SYNC_RESET}};
      sync_out <= {W{lcc_pkg::SYNC_RESET}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // lcc_sync

// ==== core/lcc_cell.sv ====
// One logic cell: lookup table, configurable register, two outputs.
// Assumes controls on the same clock; clock edges arrive as clk_pulse.
module lcc_cell (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Configuration
  input lcc_pkg::lcc_cell_cfg_t cfg,
  // Local interconnect inputs
  input wire logic [lcc_pkg::LUT_IN-1:0] data,
  input wire logic ena,
  // Chain links
  input wire logic carry_in,
  input wire logic cascade_in,
  // Shared controls
  input wire logic clk_pulse,
  input wire logic clr_n,
  input wire logic pre_n,
  input wire logic chip_clr_n,
  // Results
  output lcc_pkg::lcc_cell_out_t res,
  output logic carry_out,
  output logic cascade_out
);

  logic [lcc_pkg::LUT_IN-1:0] lut_in; // Inputs after carry insertion
  logic lut_res; // Result after cascade
  logic q; // Register state
  logic next_q;
  logic clr_eff_n; // Clear after tie-off
  logic pre_eff_n; // Preset after tie-off
  logic second; // K or R input

  // Lookup table with carry and cascade
  always_comb begin
    lut_in = data;
    if (cfg.carry_en) begin
      lut_in[lcc_pkg::IN_CARRY] = carry_in;
    end
    lut_res = cfg.lut_mask[lut_in];
    if (cfg.cascade_en) begin
      lut_res = lut_res & cascade_in;
    end
    carry_out = cfg.carry_en & ((data[0] & data[1]) |
                (carry_in & (data[0] ^ data[1])));
    cascade_out = lut_res;
  end

  // Register next state, chip clear first
  always_comb begin
    clr_eff_n = cfg.use_clr ? clr_n : 1'h1;
    pre_eff_n = cfg.use_pre ? pre_n : 1'h1;
    second = data[lcc_pkg::IN_SECOND];
    next_q = q;
    if (!chip_clr_n) begin
      next_q = lcc_pkg::Q_RESET;
    end else if (cfg.bypass) begin
      next_q = lcc_pkg::Q_RESET;
    end else if (!clr_eff_n) begin
      next_q = 1'h0;
    end else if (!pre_eff_n) begin
      next_q = 1'h1;
    end else if (clk_pulse && ena) begin
      case (cfg.ff_mode)
        lcc_pkg::LCC_FF_D: next_q = lut_res;
        lcc_pkg::LCC_FF_T: next_q = lut_res ? ~q : q;
        lcc_pkg::LCC_FF_JK: begin
          case ({lut_res, second})
            2'h2: next_q = 1'h1;
            2'h1: next_q = 1'h0;
            2'h3: next_q = ~q;
            default: next_q = q;
          endcase
        end
        default: begin
          // Set wins when set and reset meet
          if (lut_res) begin
            next_q = 1'h1;
          end else if (second) begin
            next_q = 1'h0;
          end
        end
      endcase
    end
  end

  // Register state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= lcc_pkg::Q_RESET;
    end else begin
      q <= next_q;
    end
  end

  // Two outputs, each with its own source
  always_comb begin
    res.lut = lut_res;
    res.q = q;
    res.local_o = (cfg.bypass || cfg.local_src == lcc_pkg::LCC_OUT_LUT) ?
                  lut_res : q;
    res.row_o = (cfg.bypass || cfg.row_src == lcc_pkg::LCC_OUT_LUT) ?
                lut_res : q;
  end

endmodule // lcc_cell

// ==== core/lcc_cluster.sv ====
// Cluster of eight logic cells around one local interconnect.
// Assumes config ports, global and row lines and chain links on clk;
// dedicated clock pins, I/O pins and the chip clear pin are asynchronous.

module lcc_cluster #(
  parameter int N_ROW_IN = lcc_pkg::N_ROW
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Configuration
  input lcc_pkg::lcc_cell_cfg_t [lcc_pkg::N_CELLS-1:0] cell_cfg,
  input lcc_pkg::lcc_ctrl_cfg_t [lcc_pkg::N_CTRL-1:0] ctrl_cfg,
  // Asynchronous pins
  input wire logic [lcc_pkg::N_DCLK-1:0] dclk_pin,
  input wire logic [lcc_pkg::N_IO-1:0] io_pin,
  input wire logic chip_clr_n_pin,
  // Internal lines on clk
  input wire logic [lcc_pkg::N_GLOBAL-1:0] global_sig,
  input wire logic [N_ROW_IN-1:0] row_in,
  // Links from and to the neighbouring cluster
  input wire logic carry_in,
  input wire logic cascade_in,
  output logic carry_out,
  output logic cascade_out,
  // Cell outputs
  output logic [lcc_pkg::N_CELLS-1:0] local_out,
  output logic [lcc_pkg::N_CELLS-1:0] row_out,
  // Status
  output logic [lcc_pkg::N_CELLS-1:0] cell_q,
  output logic [lcc_pkg::N_CTRL-1:0] ctrl_level
);

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NC = lcc_pkg::N_CELLS; // Cells here
  localparam int NL = N_ROW_IN + NC; // Local interconnect width
  localparam int SP = lcc_pkg::SEL_SPAN; // Reach of one index

  // Refuse sizes that an index cannot reach
  if (N_ROW_IN < 1 || NL > SP) begin : g_bad_row
    $error("lcc_cluster: row input count out of range");
  end
  if (lcc_pkg::N_DCLK > SP || lcc_pkg::N_IO > SP ||
      lcc_pkg::N_GLOBAL > SP) begin : g_bad_src
    $error("lcc_cluster: control source count out of range");
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [lcc_pkg::N_DCLK-1:0] dclk_s; // Dedicated clocks, synced
  logic [lcc_pkg::N_IO-1:0] io_s; // I/O pins, synced
  logic chip_clr_n_s; // Chip clear, synced

  // Dedicated clock pins
  lcc_sync #(.W(lcc_pkg::N_DCLK)) u_sync_dclk (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(dclk_pin),
    .sync_out(dclk_s)
  );

  // I/O pins
  lcc_sync #(.W(lcc_pkg::N_IO)) u_sync_io (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(io_pin),
    .sync_out(io_s)
  );

  // Chip clear pin; reads as asserted until two edges pass
  lcc_sync #(.W(1)) u_sync_chip (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(chip_clr_n_pin),
    .sync_out(chip_clr_n_s)
  );

  // ----------------------------------------------------------------------
  // Local interconnect
  // ----------------------------------------------------------------------
  // Feedback uses the registered local outputs, so no setting of the
  // selects can close a combinational loop through the cells.
  logic [NL-1:0] local_bus; // Row lines low, cell feedback high
  logic [SP-1:0] local_wide; // Padded for any index
  logic [SP-1:0] dclk_wide; // Padded dedicated clocks
  logic [SP-1:0] glob_wide; // Padded globals
  logic [SP-1:0] io_wide; // Padded I/O

  // Assemble and pad every source family
  always_comb begin
    local_bus = {local_out, row_in};
    local_wide = SP'(local_bus);
    dclk_wide = SP'(dclk_s);
    glob_wide = SP'(global_sig);
    io_wide = SP'(io_s);
  end

  // ----------------------------------------------------------------------
  // Shared controls
  // ----------------------------------------------------------------------
  // Raw level of one control source before inversion
  function automatic logic ctrl_pick(
    input lcc_pkg::lcc_ctrl_cfg_t c,
    input logic [SP-1:0] dk,
    input logic [SP-1:0] gl,
    input logic [SP-1:0] io,
    input logic [SP-1:0] lc
  );
    logic v;
    v = 1'h0;
    case (c.kind)
      lcc_pkg::LCC_SRC_DCLK: v = dk[c.idx];
      lcc_pkg::LCC_SRC_GLOBAL: v = gl[c.idx];
      lcc_pkg::LCC_SRC_IO: v = io[c.idx];
      default: v = lc[c.idx];
    endcase
    return v;
  endfunction

  logic [lcc_pkg::N_CTRL-1:0] level; // Control levels after inversion
  logic [1:0] clk_prev; // Cluster clock levels last cycle
  logic [1:0] next_clk_prev;
  logic [1:0] clk_pulse; // Rising edge of each cluster clock
  logic clr_n; // Cluster clear, active low
  logic pre_n; // Cluster preset, active low

  // Select and invert the four controls
  always_comb begin
    for (int k = 0; k < lcc_pkg::N_CTRL; k++) begin
      level[k] = ctrl_pick(ctrl_cfg[k], dclk_wide, glob_wide, io_wide,
                           local_wide) ^ ctrl_cfg[k].invert;
    end
    // Clear and preset refuse the dedicated clocks and stay idle
    if (ctrl_cfg[lcc_pkg::CTRL_CLR].kind == lcc_pkg::LCC_SRC_DCLK) begin
      level[lcc_pkg::CTRL_CLR] = 1'h1;
    end
    if (ctrl_cfg[lcc_pkg::CTRL_PRE].kind == lcc_pkg::LCC_SRC_DCLK) begin
      level[lcc_pkg::CTRL_PRE] = 1'h1;
    end
    clr_n = level[lcc_pkg::CTRL_CLR];
    pre_n = level[lcc_pkg::CTRL_PRE];
  end

  // Cluster clocks become one-cycle edge pulses on clk
  always_comb begin
    next_clk_prev = {level[lcc_pkg::CTRL_CLK1], level[lcc_pkg::CTRL_CLK0]};
    clk_pulse = next_clk_prev & ~clk_prev;
  end

  // Previous clock levels
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_prev <= 2'h0;
    end else begin
      clk_prev <= next_clk_prev;
    end
  end

  // ----------------------------------------------------------------------
  // Cells and chains
  // ----------------------------------------------------------------------
  lcc_pkg::lcc_cell_out_t [NC-1:0] cres; // Per-cell results
  logic [NC:0] carry; // Carry link, cell 0 at bit 0
  logic [NC:0] cascade; // Cascade link, cell 0 at bit 0
  logic [NC-1:0][lcc_pkg::LUT_IN-1:0] cdata; // Selected data inputs
  logic [NC-1:0] cena; // Selected enables
  logic [NC-1:0] cpulse; // Chosen clock pulse per cell

  // Chain ends meet the neighbouring clusters
  always_comb begin
    carry[0] = carry_in;
    cascade[0] = cascade_in;
    carry_out = carry[NC];
    cascade_out = cascade[NC];
  end

  // Each cell picks inputs, enable and clock from shared lines
  always_comb begin
    for (int i = 0; i < NC; i++) begin
      for (int j = 0; j < lcc_pkg::LUT_IN; j++) begin
        cdata[i][j] = local_wide[cell_cfg[i].in_sel[j]];
      end
      cena[i] = cell_cfg[i].ena_use ?
                local_wide[cell_cfg[i].ena_sel] : 1'h1;
      cpulse[i] = clk_pulse[cell_cfg[i].clk_sel];
    end
  end

  // Eight cells
  for (genvar i = 0; i < NC; i++) begin : g_cell
    lcc_cell u_cell (
      .clk(clk),
      .reset_n(reset_n),
      .cfg(cell_cfg[i]),
      .data(cdata[i]),
      .ena(cena[i]),
      .carry_in(carry[i]),
      .cascade_in(cascade[i]),
      .clk_pulse(cpulse[i]),
      .clr_n(clr_n),
      .pre_n(pre_n),
      .chip_clr_n(chip_clr_n_s),
      .res(cres[i]),
      .carry_out(carry[i+1]),
      .cascade_out(cascade[i+1])
    );
  end

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------
  logic [NC-1:0] next_local_out;
  logic [NC-1:0] next_row_out;
  logic [NC-1:0] next_cell_q;
  logic [lcc_pkg::N_CTRL-1:0] next_ctrl_level;

  // Gather cell outputs; chip clear drops cell_q at once
  always_comb begin
    for (int i = 0; i < NC; i++) begin
      next_local_out[i] = cres[i].local_o;
      next_row_out[i] = cres[i].row_o;
      next_cell_q[i] = cres[i].q;
    end
    next_ctrl_level = level;
    if (!chip_clr_n_s) begin
      next_cell_q = {NC{lcc_pkg::Q_RESET}};
    end
  end

  // Register every output port but carry_out and cascade_out
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      local_out <= {NC{lcc_pkg::OUT_RESET}};
      row_out <= {NC{lcc_pkg::OUT_RESET}};
      cell_q <= {NC{lcc_pkg::OUT_RESET}};
      ctrl_level <= {lcc_pkg::N_CTRL{lcc_pkg::OUT_RESET}};
    end else begin
      local_out <= next_local_out;
      row_out <= next_row_out;
      cell_q <= next_cell_q;
      ctrl_level <= next_ctrl_level;
    end
  end

endmodule // lcc_cluster

// ==== dv/lcc_cluster_properties.sv ====
// Port-level checks of the logic cell cluster.
// Assumes lcc_pkg is compiled first; bound to every lcc_cluster below.
module lcc_cluster_props #(
  parameter int N_ROW_IN = lcc_pkg::N_ROW
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Configuration
  input lcc_pkg::lcc_cell_cfg_t [lcc_pkg::N_CELLS-1:0] cell_cfg,
  input lcc_pkg::lcc_ctrl_cfg_t [lcc_pkg::N_CTRL-1:0] ctrl_cfg,
  // Pins and lines
  input wire logic [lcc_pkg::N_DCLK-1:0] dclk_pin,
  input wire logic [lcc_pkg::N_IO-1:0] io_pin,
  input wire logic chip_clr_n_pin,
  input wire logic [lcc_pkg::N_GLOBAL-1:0] global_sig,
  input wire logic [N_ROW_IN-1:0] row_in,
  // Links
  input wire logic carry_in,
  input wire logic cascade_in,
  input wire logic carry_out,
  input wire logic cascade_out,
  // Results
  input wire logic [lcc_pkg::N_CELLS-1:0] local_out,
  input wire logic [lcc_pkg::N_CELLS-1:0] row_out,
  input wire logic [lcc_pkg::N_CELLS-1:0] cell_q,
  input wire logic [lcc_pkg::N_CTRL-1:0] ctrl_level
);
  // ---------------------------------------------------------------
  // Helper vectors
  // ---------------------------------------------------------------
  logic [lcc_pkg::N_CELLS-1:0] byp; // Cells in bypass
  logic [lcc_pkg::N_CELLS-1:0] u_clr; // Cells following clear
  logic [lcc_pkg::N_CELLS-1:0] u_pre; // Cells following preset

  // Gather per-cell bits
  always_comb begin
    for (int i = 0; i < lcc_pkg::N_CELLS; i++) begin
      byp[i] = cell_cfg[i].bypass;
      u_clr[i] = cell_cfg[i].use_clr;
      u_pre[i] = cell_cfg[i].use_pre;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Chip clear held past the synchroniser
  sequence s_chip_low;
    (!chip_clr_n_pin) [*4];
  endsequence
  // No clock movement and nothing forcing the registers
  sequence s_quiet;
    ($stable(ctrl_level[1:0]) && u_clr == '0 && u_pre == '0 && byp == '0
      && chip_clr_n_pin) [*4];
  endsequence
  // Preset alone active on every cell
  sequence s_preset_only;
    (u_pre == '1 && u_clr == '0 && byp == '0 && !ctrl_level[3]
      && chip_clr_n_pin) [*5];
  endsequence

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_reset_zero: assert property ($rose(reset_n) |->
    cell_q == '0 && local_out == '0 && row_out == '0)
    else $error("outputs not zero after reset");
  a_chip_clear: assert property (s_chip_low |-> ##[0:2] cell_q == '0)
    else $error("chip clear did not clear registers");
  a_carry_off: assert property (!cell_cfg[7].carry_en |-> !carry_out)
    else $error("carry out high with carry link off");
  a_bypass_out: assert property ((byp == '1) [*4] |->
    local_out == row_out)
    else $error("bypass outputs differ");
  a_bypass_hold: assert property ((byp == '1) [*4] |-> cell_q == '0)
    else $error("register not held in bypass");
  a_clr_no_dclk: assert property (
    (ctrl_cfg[2].kind == lcc_pkg::LCC_SRC_DCLK) [*3] |-> ctrl_level[2])
    else $error("clear taken from dedicated clock");
  a_clk_follow: assert property ($rose(global_sig[0]) &&
    ctrl_cfg[0].kind == lcc_pkg::LCC_SRC_GLOBAL && ctrl_cfg[0].idx == '0
    && !ctrl_cfg[0].invert |-> ##[1:2] ctrl_level[0])
    else $error("cluster clock level did not follow source");
  a_clear_wins: assert property (
    (u_clr == '1 && !ctrl_level[2]) [*3] |-> ##[0:2] cell_q == '0)
    else $error("clear low did not clear registers");
  a_preset_sets: assert property (s_preset_only |-> ##[0:2] cell_q == '1)
    else $error("preset low did not set registers");
  a_quiet_hold: assert property (s_quiet |-> $stable(cell_q))
    else $error("register changed without a clock");
endmodule // lcc_cluster_props

bind lcc_cluster lcc_cluster_props #(.N_ROW_IN(N_ROW_IN)) props_u (
  .clk(clk), .reset_n(reset_n), .cell_cfg(cell_cfg), .ctrl_cfg(ctrl_cfg),
  .dclk_pin(dclk_pin), .io_pin(io_pin), .chip_clr_n_pin(chip_clr_n_pin),
  .global_sig(global_sig), .row_in(row_in), .carry_in(carry_in),
  .cascade_in(cascade_in), .carry_out(carry_out),
  .cascade_out(cascade_out), .local_out(local_out), .row_out(row_out),
  .cell_q(cell_q), .ctrl_level(ctrl_level)
);

// ==== dv/tb.sv ====
// Self-checking bench of the logic cell cluster.
// Assumes lcc_pkg, the design and its checker are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  lcc_pkg::lcc_cell_cfg_t [lcc_pkg::N_CELLS-1:0] cell_cfg = '0;
  lcc_pkg::lcc_ctrl_cfg_t [lcc_pkg::N_CTRL-1:0] ctrl_cfg;
  logic [lcc_pkg::N_DCLK-1:0] dclk_pin = '0;
  logic [lcc_pkg::N_IO-1:0] io_pin = '0;
  logic chip_clr_n_pin = 1'b1;
  logic [lcc_pkg::N_GLOBAL-1:0] global_sig = 4'h6; // Clear, preset idle
  logic [7:0] row_in = 8'h00;
  logic carry_in = 1'b0;
  logic cascade_in = 1'b0;
  logic carry_out, cascade_out;
  logic [7:0] local_out, row_out, cell_q;
  logic [3:0] ctrl_level;
  lcc_pkg::lcc_cell_cfg_t cc; // Template for every cell
  logic [7:0] exp_q; // Expected register state
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Mode steps: mode, data word, register state after one clock
  logic [6:0] mode_tab [15] = '{7'h00, 7'h23, 7'h22, 7'h20, 7'h43, 7'h50,
    7'h53, 7'h52, 7'h43, 7'h41, 7'h70, 7'h63, 7'h61, 7'h70, 7'h73};

  lcc_cluster #(.N_ROW_IN(8)) dut_u (
    .clk(clk), .reset_n(reset_n), .cell_cfg(cell_cfg), .ctrl_cfg(ctrl_cfg),
    .dclk_pin(dclk_pin), .io_pin(io_pin), .chip_clr_n_pin(chip_clr_n_pin),
    .global_sig(global_sig), .row_in(row_in), .carry_in(carry_in),
    .cascade_in(cascade_in), .carry_out(carry_out),
    .cascade_out(cascade_out), .local_out(local_out), .row_out(row_out),
    .cell_q(cell_q), .ctrl_level(ctrl_level)
  );

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask

  // Template into all cells, then settle
  task automatic apply();
    @(posedge clk);
    cell_cfg <= {lcc_pkg::N_CELLS{cc}};
    cyc(3);
  endtask

  task automatic set_rin(logic [7:0] v);
    @(posedge clk);
    row_in <= v;
    cyc(3);
  endtask

  task automatic set_gs(logic [3:0] v);
    @(posedge clk);
    global_sig <= v;
    cyc(5);
  endtask

  // Same level on source one of every family
  task automatic set_src(logic v);
    @(posedge clk);
    {dclk_pin[1], io_pin[1], global_sig[1], row_in[1]} <= {4{v}};
    cyc(5);
  endtask

  // One clock event on source zero of the dedicated, global and I/O families
  task automatic tick();
    @(posedge clk);
    {global_sig[0], dclk_pin[0], io_pin[0]} <= 3'h7;
    cyc(2);
    {global_sig[0], dclk_pin[0], io_pin[0]} <= 3'h0;
    cyc(7);
  endtask

  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    ctrl_cfg[0] = '{lcc_pkg::LCC_SRC_GLOBAL, 4'h0, 1'b0};
    ctrl_cfg[1] = '0;
    ctrl_cfg[2] = '{lcc_pkg::LCC_SRC_GLOBAL, 4'h1, 1'b0};
    ctrl_cfg[3] = '{lcc_pkg::LCC_SRC_GLOBAL, 4'h2, 1'b0};
    cc = '0;
    cc.in_sel = 16'h3210;
    cyc(10);
    reset_n <= 1'b1;
    cyc(5);
    // Lookup over all sixteen inputs, flop bypassed
    cc.lut_mask = 16'hA5C3;
    cc.bypass = 1'b1;
    apply();
    for (int v = 0; v < 16; v++) begin
      set_rin(8'(v));
      chk("lut_local", {8{cc.lut_mask[v]}}, local_out);
      chk("lut_row", {8{cc.lut_mask[v]}}, row_out);
    end
    chk("bypass_q", 8'h00, cell_q);
    // Register packing, then swapped sources
    cc.bypass = 1'b0;
    cc.lut_mask = 16'hAAAA;
    cc.row_src = lcc_pkg::LCC_OUT_REG;
    apply();
    set_rin(8'h01);
    tick();
    chk("pack_q", 8'hFF, cell_q);
    set_rin(8'h00);
    chk("pack_local", 8'h00, local_out);
    chk("pack_row", 8'hFF, row_out);
    cc.local_src = lcc_pkg::LCC_OUT_REG;
    cc.row_src = lcc_pkg::LCC_OUT_LUT;
    apply();
    chk("swap_local", 8'hFF, local_out);
    chk("swap_row", 8'h00, row_out);
    // Enable from row line four
    cc.ena_use = 1'b1;
    cc.ena_sel = 4'h4;
    apply();
    tick();
    chk("ena_hold", 8'hFF, cell_q);
    set_rin(8'h10);
    tick();
    chk("ena_take", 8'h00, cell_q);
    cc.ena_use = 1'b0;
    // Every register mode step by step
    foreach (mode_tab[i]) begin
      cc.ff_mode = lcc_pkg::lcc_ff_mode_t'(mode_tab[i][6:5]);
      apply();
      set_rin({4'h0, mode_tab[i][4:1]});
      tick();
      chk("mode_q", {8{mode_tab[i][0]}}, cell_q);
    end
    // Preset, clear priority, chip clear, unused controls
    cc.ff_mode = lcc_pkg::LCC_FF_D;
    cc.use_pre = 1'b1;
    apply();
    set_rin(8'h00);
    tick();
    set_gs(4'h2);
    chk("preset", 8'hFF, cell_q);
    cc.use_clr = 1'b1;
    apply();
    set_gs(4'h0);
    chk("clr_wins", 8'h00, cell_q);
    set_gs(4'h2);
    @(posedge clk);
    chip_clr_n_pin <= 1'b0;
    cyc(6);
    chk("chip_clr", 8'h00, cell_q);
    chip_clr_n_pin <= 1'b1;
    cyc(8);
    chk("chip_rel", 8'hFF, cell_q);
    cc.use_clr = 1'b0;
    cc.use_pre = 1'b0;
    apply();
    set_gs(4'h0);
    chk("unused_tied", 8'hFF, cell_q);
    set_gs(4'h6);
    // Cluster clock from dedicated, global and pin sources
    cc.ff_mode = lcc_pkg::LCC_FF_T;
    cc.lut_mask = 16'hFFFF;
    apply();
    exp_q = 8'hFF;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      ctrl_cfg[0] <= '{lcc_pkg::lcc_src_kind_t'(k), 4'h0, 1'b0};
      cyc(4);
      tick();
      exp_q = ~exp_q;
      chk("src_clk", exp_q, cell_q);
    end
    // Control levels from every source family
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      ctrl_cfg[1] <= '{lcc_pkg::lcc_src_kind_t'(k), 4'h1, 1'b0};
      set_src(1'b1);
      chk("lvl_hi", 8'h01, 8'(ctrl_level[1]));
      set_src(1'b0);
      chk("lvl_lo", 8'h00, 8'(ctrl_level[1]));
    end
    @(posedge clk);
    ctrl_cfg[1].invert <= 1'b1;
    ctrl_cfg[2] <= '{lcc_pkg::LCC_SRC_DCLK, 4'h1, 1'b0};
    cyc(5);
    chk("lvl_inv", 8'h01, 8'(ctrl_level[1]));
    chk("clr_no_dclk", 8'h01, 8'(ctrl_level[2]));
    // Carry and cascade links through all cells
    cc = '0;
    cc.in_sel = 16'h3210;
    cc.lut_mask = 16'hF0F0;
    cc.bypass = 1'b1;
    cc.carry_en = 1'b1;
    cc.cascade_en = 1'b1;
    apply();
    set_rin(8'h01);
    for (int v = 0; v < 4; v++) begin
      @(posedge clk);
      {carry_in, cascade_in} <= 2'(v);
      cyc(3);
      chk("carry_out", 8'(v[1]), 8'(carry_out));
      chk("cascade_out", 8'(v[1] & v[0]), 8'(cascade_out));
      chk("chain_local", {8{v[1] & v[0]}}, local_out);
    end
    @(posedge clk);
    carry_in <= 1'b0;
    set_rin(8'h03);
    chk("carry_gen", 8'h01, 8'(carry_out));
    give_verdict();
  end
endmodule // tb
